// ===== include/bcsu_pkg.sv
package bcsu_pkg;
	// ==========================================================
	// Scan kinds
	typedef enum logic [2:0] {
		BCSU_FIXED_MATCH = 3'h0,
		BCSU_BLOCK_MATCH = 3'h1,
		BCSU_FIXED_MISMATCH = 3'h2,
		BCSU_BLOCK_MISMATCH = 3'h3,
		BCSU_FIXED_MAGNITUDE = 3'h4
	} bcsu_kind_t;
	// ==========================================================
	// Register offsets (word index x4)
	localparam logic [3:0] BCSU_ADDR_CTRL = 4'h0;
	localparam logic [3:0] BCSU_ADDR_PTR1 = 4'h1;
	localparam logic [3:0] BCSU_ADDR_PTR2 = 4'h2;
	localparam logic [3:0] BCSU_ADDR_COUNT = 4'h3;
	localparam logic [3:0] BCSU_ADDR_ACC = 4'h4;
	localparam logic [3:0] BCSU_ADDR_STATUS = 4'h5;
	localparam logic [3:0] BCSU_ADDR_FLAGS = 4'h6;
	// ==========================================================
	// Control fields
	localparam int BCSU_CTRL_START = 0;
	localparam int BCSU_CTRL_DOWN = 1;
	localparam int BCSU_CTRL_KIND_LO = 4;
	// ==========================================================
	// Flag positions
	localparam int BCSU_FLAG_BORROW = 0;
	localparam int BCSU_FLAG_OVERFLOW = 1;
	localparam int BCSU_FLAG_HALF = 2;
	localparam int BCSU_FLAG_ZERO = 3;
	localparam int BCSU_FLAG_SIGN = 4;
	// ==========================================================
	// Reset values
	localparam logic [15:0] BCSU_PTR_RESET = 16'h0000;
	localparam logic [7:0] BCSU_BYTE_RESET = 8'h00;
	localparam logic [4:0] BCSU_FLAGS_RESET = 5'h00;
endpackage

// ===== logic/bcsu_subtract.sv
`timescale 1ns/1ps
module bcsu_subtract (
	input wire logic [7:0] minuend,
	input wire logic [7:0] subtrahend,
	output logic [7:0] difference,
	output logic [4:0] flags
);
	// ==========================================================
	// Bitwise borrow chain
	logic [8:0] borrow;
	assign borrow[0] = 1'b0;
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_bit
			assign difference[i] = minuend[i] ^ subtrahend[i] ^ borrow[i];
			assign borrow[i+1] = (~minuend[i] & subtrahend[i]) |
				(~(minuend[i] ^ subtrahend[i]) & borrow[i]);
		end
	endgenerate
	assign flags[bcsu_pkg::BCSU_FLAG_SIGN] = difference[7];
	assign flags[bcsu_pkg::BCSU_FLAG_ZERO] = difference == 8'h00;
	assign flags[bcsu_pkg::BCSU_FLAG_HALF] = borrow[4];
	assign flags[bcsu_pkg::BCSU_FLAG_OVERFLOW] = borrow[7] ^ borrow[8];
	assign flags[bcsu_pkg::BCSU_FLAG_BORROW] = borrow[8];
endmodule // bcsu_subtract

// ===== logic/bcsu_unit.sv
`timescale 1ns/1ps
module bcsu_unit (
	input wire logic clk,
	input wire logic srst,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [15:0] mem_address,
	output logic mem_read,
	input wire logic [7:0] mem_readdata,
	input wire logic mem_waitrequest,
	input wire logic service_request,
	input wire logic macro_service,
	output logic service_ack,
	input wire logic service_done,
	output logic busy,
	output logic suspended
);
	// ==========================================================
	// Sequencer states
	typedef enum logic [2:0] {
		S_IDLE, S_FETCH1, S_FETCH2, S_STEP, S_HELD
	} bcsu_state_t;
	bcsu_state_t state, next_state;
	// ==========================================================
	// Registers
	logic [15:0] first_block_pointer;
	logic [15:0] second_block_pointer;
	logic [7:0] count;
	logic [7:0] accumulator;
	logic [7:0] byte1;
	logic [7:0] byte2;
	logic [4:0] flags;
	logic [2:0] kind_reg;
	logic down;
	logic macro_held;
	logic rd_hold;
	// ==========================================================
	// Bus decode
	logic [3:0] word;
	logic hit_ctrl, hit_ptr1, hit_ptr2, hit_count, hit_acc;
	logic wr_ok, start_req;
	logic rd_wait, wr_wait;
	logic wr_ptr1, wr_ptr2, wr_count, wr_acc;
	assign word = avs_address[5:2];
	assign hit_ctrl = word == bcsu_pkg::BCSU_ADDR_CTRL;
	assign hit_ptr1 = word == bcsu_pkg::BCSU_ADDR_PTR1;
	assign hit_ptr2 = word == bcsu_pkg::BCSU_ADDR_PTR2;
	assign hit_count = word == bcsu_pkg::BCSU_ADDR_COUNT;
	assign hit_acc = word == bcsu_pkg::BCSU_ADDR_ACC;
	// Writes wait while a scan runs so software never corrupts a step
	assign wr_wait = avs_write & (state != S_IDLE) & (state != S_HELD);
	// Reads wait one cycle: registered data then stands at the taking edge
	assign rd_wait = avs_read & ~rd_hold;
	assign avs_waitrequest = rd_wait | wr_wait;
	assign wr_ok = avs_write & ~wr_wait;
	assign start_req = wr_ok & hit_ctrl & avs_byteenable[0] &
		avs_writedata[bcsu_pkg::BCSU_CTRL_START];
	assign wr_ptr1 = wr_ok & hit_ptr1;
	assign wr_ptr2 = wr_ok & hit_ptr2;
	assign wr_count = wr_ok & hit_count;
	assign wr_acc = wr_ok & hit_acc;
	// ==========================================================
	// Step datapath
	logic [7:0] diff;
	logic [4:0] step_flags;
	logic [7:0] rhs;
	logic block_kind, stop_hit, last_step;
	logic [7:0] next_count;
	logic [15:0] delta;
	assign block_kind = (kind_reg == bcsu_pkg::BCSU_BLOCK_MATCH) |
		(kind_reg == bcsu_pkg::BCSU_BLOCK_MISMATCH);
	assign rhs = block_kind ? byte2 : accumulator;
	bcsu_subtract u_sub (
		.minuend(byte1),
		.subtrahend(rhs),
		.difference(diff),
		.flags(step_flags)
	);
	always_comb begin
		unique case (kind_reg)
			bcsu_pkg::BCSU_FIXED_MATCH,
			bcsu_pkg::BCSU_BLOCK_MATCH:
				stop_hit = ~step_flags[bcsu_pkg::BCSU_FLAG_ZERO];
			bcsu_pkg::BCSU_FIXED_MISMATCH,
			bcsu_pkg::BCSU_BLOCK_MISMATCH:
				stop_hit = step_flags[bcsu_pkg::BCSU_FLAG_ZERO];
			bcsu_pkg::BCSU_FIXED_MAGNITUDE:
				stop_hit = ~step_flags[bcsu_pkg::BCSU_FLAG_BORROW];
			default:
				stop_hit = 1'b1;
		endcase
	end
	// Count drops before the test, so zero wraps to 255: 256 steps
	assign next_count = count - 8'h01;
	assign last_step = (next_count == 8'h00) | stop_hit;
	assign delta = down ? 16'hFFFF : 16'h0001;
	// ==========================================================
	// Memory port, read only
	assign mem_read = (state == S_FETCH1) | (state == S_FETCH2);
	assign mem_address = (state == S_FETCH2) ? second_block_pointer :
		first_block_pointer;
	assign busy = state != S_IDLE;
	assign suspended = state == S_HELD;
	// Ack only between steps, never mid-fetch
	assign service_ack = (state == S_FETCH1) & service_request &
		~mem_waitrequest;
	// ==========================================================
	// Step events
	logic fetch1_done, fetch2_done, resume_macro;
	assign fetch1_done = (state == S_FETCH1) & ~mem_waitrequest;
	assign fetch2_done = (state == S_FETCH2) & ~mem_waitrequest;
	// Macro service resumes by itself; an interrupt needs a fresh start
	assign resume_macro = macro_held & service_done;
	// ==========================================================
	// Next state
	always_comb begin
		next_state = state;
		unique case (state)
			S_IDLE:
				if (start_req) begin
					next_state = S_FETCH1;
				end
			S_FETCH1:
				// Leave only once mem_waitrequest drops, so a waiting read is never dropped
				if (service_ack) begin
					next_state = S_HELD;
				end else if (fetch1_done) begin
					next_state = block_kind ? S_FETCH2 : S_STEP;
				end
			S_FETCH2:
				if (fetch2_done) begin
					next_state = S_STEP;
				end
			S_STEP:
				next_state = last_step ? S_IDLE : S_FETCH1;
			S_HELD:
				// Return from interrupt restarts via the start bit
				if (resume_macro) begin
					next_state = S_FETCH1;
				end else if (start_req) begin
					next_state = S_FETCH1;
				end
		endcase
	end
	// ==========================================================
	// Sequencer and operand capture
	always_ff @(posedge clk) begin
		if (srst) begin
			state <= S_IDLE;
		end else begin
			state <= next_state;
		end
	end
	// Service kind is latched at the ack; the request may drop after
	always_ff @(posedge clk) begin
		if (srst) begin
			macro_held <= 1'b0;
		end else if (service_ack) begin
			macro_held <= macro_service;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			byte1 <= bcsu_pkg::BCSU_BYTE_RESET;
		end else if (fetch1_done) begin
			byte1 <= mem_readdata;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			byte2 <= bcsu_pkg::BCSU_BYTE_RESET;
		end else if (fetch2_done) begin
			byte2 <= mem_readdata;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			rd_hold <= 1'b0;
		end else begin
			rd_hold <= rd_wait;
		end
	end
	// ==========================================================
	// Architectural registers
	logic stepping;
	assign stepping = state == S_STEP;
	// Writes stall during a step, so a step never meets a bus write
	always_ff @(posedge clk) begin
		if (srst) begin
			first_block_pointer <= bcsu_pkg::BCSU_PTR_RESET;
		end else if (stepping) begin
			first_block_pointer <= first_block_pointer + delta;
		end else if (wr_ptr1) begin
			first_block_pointer <= avs_writedata[15:0];
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			second_block_pointer <= bcsu_pkg::BCSU_PTR_RESET;
		end else if (stepping & block_kind) begin
			second_block_pointer <= second_block_pointer + delta;
		end else if (wr_ptr2) begin
			second_block_pointer <= avs_writedata[15:0];
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			count <= bcsu_pkg::BCSU_BYTE_RESET;
		end else if (stepping) begin
			count <= next_count;
		end else if (wr_count) begin
			count <= avs_writedata[7:0];
		end
	end
	// No scan path writes the accumulator
	always_ff @(posedge clk) begin
		if (srst) begin
			accumulator <= bcsu_pkg::BCSU_BYTE_RESET;
		end else if (wr_acc) begin
			accumulator <= avs_writedata[7:0];
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			flags <= bcsu_pkg::BCSU_FLAGS_RESET;
		end else if (stepping) begin
			flags <= step_flags;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			kind_reg <= 3'h0;
			down <= 1'b0;
		end else if (start_req) begin
			down <= avs_writedata[bcsu_pkg::BCSU_CTRL_DOWN];
			kind_reg <= avs_writedata[bcsu_pkg::BCSU_CTRL_KIND_LO +: 3];
		end
	end
	// ==========================================================
	// Read mux
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (word)
			bcsu_pkg::BCSU_ADDR_CTRL:
				rd_mux = {25'h0, kind_reg, 2'h0, down, 1'b0};
			bcsu_pkg::BCSU_ADDR_PTR1:
				rd_mux = {16'h0, first_block_pointer};
			bcsu_pkg::BCSU_ADDR_PTR2:
				rd_mux = {16'h0, second_block_pointer};
			bcsu_pkg::BCSU_ADDR_COUNT:
				rd_mux = {24'h0, count};
			bcsu_pkg::BCSU_ADDR_ACC:
				rd_mux = {24'h0, accumulator};
			bcsu_pkg::BCSU_ADDR_STATUS:
				rd_mux = {29'h0, macro_held, suspended, busy};
			bcsu_pkg::BCSU_ADDR_FLAGS:
				rd_mux = {27'h0, flags};
			default:
				rd_mux = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (rd_wait) begin
			avs_readdata <= rd_mux;
		end
	end
endmodule // bcsu_unit

// ===== testbench/bcsu_checker.sv
`timescale 1ns/1ps
module bcsu_checker (
	input wire logic clk,
	input wire logic srst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic [15:0] mem_address,
	input wire logic mem_read,
	input wire logic mem_waitrequest,
	input wire logic service_request,
	input wire logic macro_service,
	input wire logic service_ack,
	input wire logic service_done,
	input wire logic busy,
	input wire logic suspended
);
	// ==========
	// Helper
	// Service kind of the last ack; it decides how a hold may end
	logic macro_seen;
	always_ff @(posedge clk) begin
		if (srst) begin
			macro_seen <= 1'b0;
		end else if (service_ack) begin
			macro_seen <= macro_service;
		end
	end
	// ==========
	// Properties
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	sequence s_ack;
		service_ack && service_request;
	endsequence
	sequence s_macro_done;
		suspended && service_done && macro_seen;
	endsequence
	sequence s_irq_held;
		suspended && !macro_seen && !avs_write;
	endsequence
	sequence s_wait_ok;
		avs_read || (avs_write && busy);
	endsequence
	sequence s_mem_wait;
		mem_read && mem_waitrequest;
	endsequence
	sequence s_mem_same;
		mem_read && $stable(mem_address);
	endsequence
	sequence s_gap;
		busy && !suspended && !mem_read;
	endsequence
	sequence s_moving;
		mem_read || !busy || suspended;
	endsequence
	AST_ACK_CAUSE: assert property (service_ack |-> service_request)
		else $error("ack without request");
	AST_ACK_HOLD: assert property (s_ack |=> suspended)
		else $error("ack did not suspend");
	AST_HELD_QUIET: assert property (suspended |-> busy && !mem_read)
		else $error("fetch while held");
	AST_MACRO_RESUME: assert property (s_macro_done |=> !suspended)
		else $error("no resume after done");
	AST_IRQ_STAY: assert property (s_irq_held |=> suspended)
		else $error("interrupt hold lost");
	AST_IDLE_QUIET: assert property (!busy |-> !mem_read && !suspended)
		else $error("idle unit active");
	AST_WAIT_CAUSE: assert property (avs_waitrequest |-> s_wait_ok)
		else $error("stray waitrequest");
	AST_ADDR_HOLD: assert property (s_mem_wait |=> s_mem_same)
		else $error("address moved");
	AST_NEXT_FETCH: assert property (s_gap |-> ##[1:2] s_moving)
		else $error("step stalled");
endmodule // bcsu_checker

bind bcsu_unit bcsu_checker i_bcsu_checker (.clk, .srst, .avs_read,
	.avs_write, .avs_waitrequest, .mem_address, .mem_read,
	.mem_waitrequest, .service_request, .macro_service, .service_ack,
	.service_done, .busy, .suspended);

// ===== testbench/bcsu_mem_model.sv
`timescale 1ns/1ps
module bcsu_mem_model (
	input wire logic clk,
	input wire logic slow,
	input wire logic [15:0] mem_address,
	input wire logic mem_read,
	output logic [7:0] mem_readdata,
	output logic mem_waitrequest
);
	// ==========
	// Read only store, no write path at all
	logic [7:0] mem [0:65535];
	logic [7:0] last = 8'h00;
	logic tog = 1'h0;
	assign mem_waitrequest = slow & tog;
	// Released bus shows the last byte inverted, then alternates with the last byte itself each cycle
	assign mem_readdata = mem_read ? mem[mem_address] : ~last;
	always_ff @(posedge clk) begin
		tog <= ~tog;
		last <= mem_readdata;
	end
endmodule // bcsu_mem_model

// ===== testbench/block_compare_string_unit_tb_top.sv
`timescale 1ns/1ps
module block_compare_string_unit_tb_top;
	logic clk = 1'h0, srst = 1'h1, avs_read = 1'h0, avs_write = 1'h0;
	logic service_request = 1'h0, macro_service = 1'h0, service_done = 1'h0;
	logic slow = 1'h0, avs_waitrequest, mem_read, mem_waitrequest;
	logic service_ack, busy, suspended;
	logic [5:0] avs_address = 6'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, ctl;
	logic [15:0] mem_address, e_p1, e_p2;
	logic [7:0] mem_readdata, e_c;
	logic [4:0] e_f;
	int bad_count = 0, checked = 0;
	always #12.5 clk = ~clk;
	bcsu_unit i_bcsu_unit (.clk, .srst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
		.mem_address, .mem_read, .mem_readdata, .mem_waitrequest,
		.service_request, .macro_service, .service_ack, .service_done,
		.busy, .suspended);
	bcsu_mem_model i_mem (.clk, .slow, .mem_address, .mem_read,
		.mem_readdata, .mem_waitrequest);
	// ==========
	// Tasks
	task conclude;
		$display("mismatches %0d comparisons %0d", bad_count, checked);
		if (bad_count == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task wr(input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'h1;
		@(posedge clk);
		while (avs_waitrequest !== 1'h0) begin
			n++;
			if (n > 3000) begin
				bad_count++;
				conclude;
			end
			@(posedge clk);
		end
		avs_write <= 1'h0;
		@(posedge clk);
	endtask
	// Read held until waitrequest drops; data is taken at that edge
	task rdr(input logic [5:0] a);
		int n;
		n = 0;
		avs_address <= a;
		avs_read <= 1'h1;
		@(posedge clk);
		while (avs_waitrequest !== 1'h0) begin
			n++;
			if (n > 3000) begin
				bad_count++;
				conclude;
			end
			@(posedge clk);
		end
		rd = avs_readdata;
		avs_read <= 1'h0;
		@(posedge clk);
	endtask
	task go(input logic [2:0] k, input logic dn, input logic [15:0] p1,
		input logic [15:0] p2, input logic [7:0] c, input logic [7:0] a);
		logic [7:0] x, y, d;
		logic stp;
		wr(6'h04, {16'h0, p1});
		wr(6'h08, {16'h0, p2});
		wr(6'h0C, {24'h0, c});
		wr(6'h10, {24'h0, a});
		e_p1 = p1;
		e_p2 = p2;
		e_c = c;
		do begin
			x = i_mem.mem[e_p1];
			y = k[0] ? i_mem.mem[e_p2] : a;
			d = x - y;
			e_f = {d[7], d == 8'h00, x[3:0] < y[3:0],
				(x[6:0] < y[6:0]) ^ (x < y), x < y};
			e_p1 = dn ? e_p1 - 16'h1 : e_p1 + 16'h1;
			if (k[0]) e_p2 = dn ? e_p2 - 16'h1 : e_p2 + 16'h1;
			e_c = e_c - 8'h01;
			stp = (k < 3'h2) ? !e_f[3] : (k == 3'h4) ? !e_f[0] : e_f[3];
		end while (e_c != 8'h00 && !stp);
		ctl = {25'h0, k, 2'h0, dn, 1'h1};
		wr(6'h00, ctl);
	endtask
	task fin;
		int n;
		n = 0;
		while (busy !== 1'h0) begin
			n++;
			if (n > 3000) begin
				bad_count++;
				conclude;
			end
			@(posedge clk);
		end
		rdr(6'h04); chk("ptr1", {16'h0, e_p1}, rd);
		rdr(6'h08); chk("ptr2", {16'h0, e_p2}, rd);
		rdr(6'h0C); chk("count", {24'h0, e_c}, rd);
		rdr(6'h18); chk("flags", {27'h0, e_f}, rd);
	endtask
	task svc(input logic m);
		int n;
		n = 0;
		service_request <= 1'h1;
		macro_service <= m;
		do begin
			@(negedge clk);
			n++;
		end while (service_ack !== 1'h1 && n < 100);
		if (n >= 100) begin
			bad_count++;
			conclude;
		end
		@(posedge clk);
		service_request <= 1'h0;
		@(posedge clk);
		rdr(6'h14); chk("status", m ? 32'h7 : 32'h3, rd);
	endtask
	// ==========
	// Main sequence
	initial begin
		for (int i = 0; i < 65536; i++) i_mem.mem[i] = i < 2048 ? i[7:0] : 8'h00;
		i_mem.mem[16'h0114] = 8'hFF;
		i_mem.mem[16'h0035] = 8'h24;
		repeat (20) @(posedge clk);
		srst <= 1'h0;
		@(posedge clk);
		rdr(6'h18); chk("flags_rst", 32'h0, rd);
		rdr(6'h1C); chk("unmapped", 32'h0, rd);
		go(3'h0, 1'h0, 16'h0100, 16'h0, 8'h05, 8'h00); fin;
		go(3'h0, 1'h0, 16'h0010, 16'h0, 8'h03, 8'h90); fin;
		go(3'h1, 1'h0, 16'h0010, 16'h0110, 8'h06, 8'h00); fin;
		go(3'h1, 1'h1, 16'h001F, 16'h011F, 8'h04, 8'h00); fin;
		go(3'h2, 1'h1, 16'h004A, 16'h0, 8'h0A, 8'h45); fin;
		go(3'h3, 1'h0, 16'h0020, 16'h0031, 8'h08, 8'h00); fin;
		slow <= 1'h1;
		go(3'h4, 1'h0, 16'h007C, 16'h0, 8'h08, 8'h80); fin;
		slow <= 1'h0;
		rdr(6'h10); chk("acc", 32'h80, rd);
		go(3'h0, 1'h0, 16'h0900, 16'h0, 8'h00, 8'h00); fin;
		go(3'h0, 1'h0, 16'h0900, 16'h0, 8'h00, 8'h00); svc(1'h1);
		service_done <= 1'h1;
		@(posedge clk);
		service_done <= 1'h0;
		fin;
		go(3'h0, 1'h0, 16'h0900, 16'h0, 8'h00, 8'h00); svc(1'h0);
		wr(6'h00, ctl); fin;
		conclude;
	end
endmodule // block_compare_string_unit_tb_top
